//--- verilog/pw_pkg.sv
// Summary of operation
// R1 - Each tunnel packet carries 32-bit session identifier
// R2 - Session identifier directly follows IP header
// R3 - Stream mode payload: subheader, 188-byte packets
// R4 - Stream mode sequence numbers reveal lost packets
// R5 - Streaming mode carries concatenated or fragmented frames
// R6 - Multicarrier channels streaming mode, single-carrier stream mode
// R7 - Downstream tunnel framing removed, payload forwarded
// R8 - Upstream frames wrapped and sent to core
// R9 - Bandwidth requests use separate priority session
// R10 - One session per channel, own marking
// R11 - Core sends maps on own low-latency flow
// R12 - Unknown session packets are discarded entirely
package pw_pkg;
  // =============================================
  // Sizes
  localparam int NUM_DS = 4;
  localparam int NUM_US = 2;
  localparam int DS_IDX_W = 2;
  localparam int US_IDX_W = 1;
  localparam int SID_W = 32;
  localparam int SEQ_W = 16;
  localparam int DSCP_W = 6;
  // =============================================
  // Framing constants
  localparam logic [7:0] SID_LAST = 8'h03;
  localparam logic [7:0] SUB_SEQ_HI = 8'h02;
  localparam logic [7:0] SUB_LAST = 8'h03;
  localparam logic [7:0] TS_LAST = 8'hBB;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [15:0] SEQ_ONE = 16'h0001;
  // =============================================
  // States
  typedef enum logic [2:0] {
    DS_IP = 3'b000,
    DS_SID = 3'b001,
    DS_SUB = 3'b011,
    DS_PAY = 3'b010,
    DS_DROP = 3'b110
  } ds_state_e;
  typedef enum logic [1:0] {
    US_IDLE = 2'b00,
    US_SID = 2'b01,
    US_PAY = 2'b11
  } us_state_e;
endpackage

//--- verilog/cable_phy_pseudowire_framer.sv
`timescale 1ns/10ps
module cable_phy_pseudowire_framer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Session configuration
  input wire logic [pw_pkg::NUM_DS-1:0] cfg_ds_en,
  input wire logic [pw_pkg::NUM_DS-1:0][pw_pkg::SID_W-1:0] cfg_ds_sid,
  input wire logic [pw_pkg::NUM_DS-1:0] cfg_ds_ofdm,
  input wire logic [pw_pkg::NUM_US-1:0][pw_pkg::SID_W-1:0] cfg_us_sid,
  input wire logic [pw_pkg::NUM_US-1:0][pw_pkg::SID_W-1:0] cfg_us_req_sid,
  input wire logic [pw_pkg::NUM_US-1:0][pw_pkg::DSCP_W-1:0] cfg_us_dscp,
  input wire logic [pw_pkg::NUM_US-1:0][pw_pkg::DSCP_W-1:0] cfg_us_req_dscp,
  // Downstream from network port
  input wire logic [7:0] ds_in_data,
  input wire logic ds_in_valid,
  input wire logic ds_in_sop,
  input wire logic ds_in_eop,
  output logic ds_in_ready,
  // Downstream toward modulator
  output logic [7:0] ds_out_data,
  output logic ds_out_valid,
  output logic ds_out_last,
  output logic ds_out_tsp_start,
  output logic ds_out_psp,
  output logic [pw_pkg::DS_IDX_W-1:0] ds_out_chan,
  input wire logic ds_out_ready,
  // Downstream events
  output logic ds_seq_gap,
  output logic ds_unknown_sess,
  output logic ds_ts_short,
  // Upstream from demodulator
  input wire logic [7:0] us_in_data,
  input wire logic us_in_valid,
  input wire logic us_in_sop,
  input wire logic us_in_eop,
  input wire logic us_in_is_req,
  input wire logic [pw_pkg::US_IDX_W-1:0] us_in_chan,
  output logic us_in_ready,
  // Upstream toward network port
  output logic [7:0] us_out_data,
  output logic us_out_valid,
  output logic us_out_sop,
  output logic us_out_eop,
  output logic us_out_prio,
  output logic [pw_pkg::DSCP_W-1:0] us_out_dscp,
  input wire logic us_out_ready
);
  import pw_pkg::*;

  // =============================================
  // Downstream state
  ds_state_e ds_state_reg, ds_state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [5:0] hlen_reg, hlen_next;
  logic [23:0] sid_reg, sid_next;
  logic [DS_IDX_W-1:0] idx_reg, idx_next;
  logic psp_reg, psp_next;
  logic [7:0] seq_hi_reg, seq_hi_next;
  logic [NUM_DS-1:0][SEQ_W-1:0] exp_reg, exp_next;
  logic [NUM_DS-1:0] known_reg, known_next;
  logic [7:0] od_reg, od_next;
  logic ov_reg, ov_next;
  logic olast_reg, olast_next;
  logic otsp_reg, otsp_next;
  logic opsp_reg, opsp_next;
  logic [DS_IDX_W-1:0] ochan_reg, ochan_next;
  logic gap_reg, gap_next;
  logic unk_reg, unk_next;
  logic short_reg, short_next;
  logic ds_adv, ds_fire;
  logic [NUM_DS-1:0] hit_vec;
  logic hit;
  logic [DS_IDX_W-1:0] hit_idx;
  logic [SEQ_W-1:0] rx_seq;

  // One output stage; a held byte stalls the whole parser
  assign ds_adv = ~ov_reg | ds_out_ready;
  assign ds_in_ready = ds_adv;
  assign ds_fire = ds_in_valid & ds_adv;
  assign rx_seq = {seq_hi_reg, ds_in_data};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DS; gi++) begin : g_match
      assign hit_vec[gi] = cfg_ds_en[gi] &&
        (cfg_ds_sid[gi] == {sid_reg, ds_in_data}); // R1
    end
  endgenerate

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = NUM_DS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit = 1'b1;
        hit_idx = DS_IDX_W'(i);
      end
    end
  end

  always_comb begin
    ds_state_next = ds_state_reg;
    cnt_next = cnt_reg;
    hlen_next = hlen_reg;
    sid_next = sid_reg;
    idx_next = idx_reg;
    psp_next = psp_reg;
    seq_hi_next = seq_hi_reg;
    exp_next = exp_reg;
    known_next = known_reg;
    od_next = od_reg;
    ov_next = ov_reg & ~ds_out_ready;
    olast_next = olast_reg;
    otsp_next = otsp_reg;
    opsp_next = opsp_reg;
    ochan_next = ochan_reg;
    gap_next = 1'b0;
    unk_next = 1'b0;
    short_next = 1'b0;
    if (ds_fire) begin
      if (ds_in_sop) begin
        // Header length in bytes, from the IHL nibble given in words
        hlen_next = {ds_in_data[3:0], 2'b00}; // R2
        cnt_next = CNT_ONE;
        ds_state_next = DS_IP;
      end else begin
        unique case (ds_state_reg)
          DS_IP: begin
            cnt_next = cnt_reg + CNT_ONE;
            if (cnt_reg == {2'b00, hlen_reg} - CNT_ONE) begin // R2
              cnt_next = CNT_ZERO;
              ds_state_next = DS_SID;
            end
          end
          DS_SID: begin
            sid_next = {sid_reg[15:0], ds_in_data};
            cnt_next = cnt_reg + CNT_ONE;
            if (cnt_reg == SID_LAST) begin
              cnt_next = CNT_ZERO;
              idx_next = hit_idx;
              psp_next = cfg_ds_ofdm[hit_idx]; // R6
              if (!hit) begin
                unk_next = 1'b1;
                ds_state_next = DS_DROP; // R12
              end else if (cfg_ds_ofdm[hit_idx]) begin
                ds_state_next = DS_PAY; // R5
              end else begin
                ds_state_next = DS_SUB; // R3
              end
            end
          end
          DS_SUB: begin
            cnt_next = cnt_reg + CNT_ONE;
            if (cnt_reg == SUB_SEQ_HI) begin
              seq_hi_next = ds_in_data;
            end
            if (cnt_reg == SUB_LAST) begin
              cnt_next = CNT_ZERO;
              ds_state_next = DS_PAY;
              if (known_reg[idx_reg] && rx_seq != exp_reg[idx_reg]) begin
                gap_next = 1'b1; // R4
              end
              exp_next[idx_reg] = rx_seq + SEQ_ONE; // R4
              known_next[idx_reg] = 1'b1;
            end
          end
          DS_PAY: begin
            // Payload leaves with tunnel framing already stripped
            ov_next = 1'b1; // R7
            od_next = ds_in_data;
            olast_next = ds_in_eop; // R5
            opsp_next = psp_reg;
            ochan_next = idx_reg;
            otsp_next = ~psp_reg && cnt_reg == CNT_ZERO; // R3
            cnt_next = cnt_reg + CNT_ONE;
            if (psp_reg || cnt_reg == TS_LAST) begin
              cnt_next = CNT_ZERO; // R3
            end
            if (ds_in_eop && !psp_reg && cnt_reg != TS_LAST) begin
              short_next = 1'b1; // R3
            end
          end
          DS_DROP: begin
            cnt_next = cnt_reg;
          end
          default: begin
            ds_state_next = DS_DROP;
          end
        endcase
      end
      if (ds_in_eop) begin
        ds_state_next = DS_IP;
        cnt_next = CNT_ZERO;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ds_state_reg <= DS_IP;
      cnt_reg <= '0;
      hlen_reg <= '0;
      sid_reg <= '0;
      idx_reg <= '0;
      psp_reg <= 1'b0;
      seq_hi_reg <= '0;
      exp_reg <= '0;
      known_reg <= '0;
      od_reg <= '0;
      ov_reg <= 1'b0;
      olast_reg <= 1'b0;
      otsp_reg <= 1'b0;
      opsp_reg <= 1'b0;
      ochan_reg <= '0;
      gap_reg <= 1'b0;
      unk_reg <= 1'b0;
      short_reg <= 1'b0;
    end else begin
      ds_state_reg <= ds_state_next;
      cnt_reg <= cnt_next;
      hlen_reg <= hlen_next;
      sid_reg <= sid_next;
      idx_reg <= idx_next;
      psp_reg <= psp_next;
      seq_hi_reg <= seq_hi_next;
      exp_reg <= exp_next;
      known_reg <= known_next;
      od_reg <= od_next;
      ov_reg <= ov_next;
      olast_reg <= olast_next;
      otsp_reg <= otsp_next;
      opsp_reg <= opsp_next;
      ochan_reg <= ochan_next;
      gap_reg <= gap_next;
      unk_reg <= unk_next;
      short_reg <= short_next;
    end
  end

  assign ds_out_data = od_reg;
  assign ds_out_valid = ov_reg;
  assign ds_out_last = olast_reg;
  assign ds_out_tsp_start = otsp_reg;
  assign ds_out_psp = opsp_reg;
  assign ds_out_chan = ochan_reg;
  assign ds_seq_gap = gap_reg;
  assign ds_unknown_sess = unk_reg;
  assign ds_ts_short = short_reg;

  // =============================================
  // Upstream encapsulation
  // The IP header itself is prepended by the network port
  us_state_e us_state_reg, us_state_next;
  logic [1:0] ucnt_reg, ucnt_next;
  logic [SID_W-1:0] usid_reg, usid_next;
  logic [7:0] ud_reg, ud_next;
  logic uv_reg, uv_next;
  logic usop_reg, usop_next;
  logic ueop_reg, ueop_next;
  logic uprio_reg, uprio_next;
  logic [DSCP_W-1:0] udscp_reg, udscp_next;
  logic us_adv;

  assign us_adv = ~uv_reg | us_out_ready;
  assign us_in_ready = us_adv && us_state_reg == US_PAY;

  always_comb begin
    us_state_next = us_state_reg;
    ucnt_next = ucnt_reg;
    usid_next = usid_reg;
    ud_next = ud_reg;
    uv_next = uv_reg & ~us_out_ready;
    usop_next = usop_reg;
    ueop_next = ueop_reg;
    uprio_next = uprio_reg;
    udscp_next = udscp_reg;
    unique case (us_state_reg)
      US_IDLE: begin
        if (us_in_valid && us_in_sop && us_adv) begin
          // Requests bypass data on their own session
          uprio_next = us_in_is_req; // R9
          usid_next = us_in_is_req ? cfg_us_req_sid[us_in_chan]
                                   : cfg_us_sid[us_in_chan]; // R10
          udscp_next = us_in_is_req ? cfg_us_req_dscp[us_in_chan]
                                    : cfg_us_dscp[us_in_chan]; // R10
          ucnt_next = 2'b00;
          us_state_next = US_SID;
        end
      end
      US_SID: begin
        if (us_adv) begin
          uv_next = 1'b1; // R8
          ud_next = usid_reg[SID_W-1 -: 8]; // R1
          usid_next = {usid_reg[SID_W-9:0], 8'h00};
          usop_next = ucnt_reg == 2'b00;
          ueop_next = 1'b0;
          ucnt_next = ucnt_reg + 2'b01;
          if (ucnt_reg == SID_LAST[1:0]) begin
            us_state_next = US_PAY;
          end
        end
      end
      US_PAY: begin
        if (us_in_valid && us_adv) begin
          uv_next = 1'b1; // R8
          ud_next = us_in_data;
          usop_next = 1'b0;
          ueop_next = us_in_eop;
          if (us_in_eop) begin
            us_state_next = US_IDLE;
          end
        end
      end
      default: begin
        us_state_next = US_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      us_state_reg <= US_IDLE;
      ucnt_reg <= '0;
      usid_reg <= '0;
      ud_reg <= '0;
      uv_reg <= 1'b0;
      usop_reg <= 1'b0;
      ueop_reg <= 1'b0;
      uprio_reg <= 1'b0;
      udscp_reg <= '0;
    end else begin
      us_state_reg <= us_state_next;
      ucnt_reg <= ucnt_next;
      usid_reg <= usid_next;
      ud_reg <= ud_next;
      uv_reg <= uv_next;
      usop_reg <= usop_next;
      ueop_reg <= ueop_next;
      uprio_reg <= uprio_next;
      udscp_reg <= udscp_next;
    end
  end

  assign us_out_data = ud_reg;
  assign us_out_valid = uv_reg;
  assign us_out_sop = usop_reg;
  assign us_out_eop = ueop_reg;
  assign us_out_prio = uprio_reg;
  assign us_out_dscp = udscp_reg;

  // =============================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_unknown_drop: assert property ( // R12
    ds_state_reg == DS_DROP && ds_adv |=> !ds_out_valid)
    else $error("payload forwarded from unknown session");
  chk_sid_match: assert property ( // R1
    ds_state_reg == DS_SID && ds_fire && !ds_in_sop && !ds_in_eop &&
    cnt_reg == SID_LAST && hit |=> ds_state_reg != DS_DROP)
    else $error("configured session was dropped");
  chk_ip_skip: assert property ( // R2
    ds_state_reg == DS_IP && ds_fire && !ds_in_sop && !ds_in_eop &&
    cnt_reg == {2'b00, hlen_reg} - CNT_ONE |=> ds_state_reg == DS_SID)
    else $error("session id not taken after IP header");
  chk_seq_gap: assert property ( // R4
    ds_state_reg == DS_SUB && ds_fire && !ds_in_sop &&
    cnt_reg == SUB_LAST && known_reg[idx_reg] &&
    rx_seq != exp_reg[idx_reg] |=> ds_seq_gap)
    else $error("sequence gap not flagged");
  chk_ts_bound: assert property ( // R3
    ds_state_reg == DS_PAY && !psp_reg |-> cnt_reg <= TS_LAST)
    else $error("stream packet count overran");
  chk_mode_chan: assert property ( // R6
    ds_out_valid |-> ds_out_psp == cfg_ds_ofdm[ds_out_chan] ||
    $changed(cfg_ds_ofdm))
    else $error("payload mode does not match channel");
  chk_pay_pass: assert property ( // R7
    ds_state_reg == DS_PAY && ds_fire && !ds_in_sop |=>
    ds_out_valid && ds_out_data == $past(ds_in_data))
    else $error("payload byte not forwarded");
  chk_frame_end: assert property ( // R5
    ds_state_reg == DS_PAY && ds_fire && !ds_in_sop && ds_in_eop
    |=> ds_out_last)
    else $error("frame end lost");
  chk_us_header: assert property ( // R8
    us_state_reg == US_SID && us_adv && ucnt_reg == SID_LAST[1:0]
    |=> us_state_reg == US_PAY ##0 us_out_valid)
    else $error("upstream header not completed");
  chk_req_sess: assert property ( // R9
    us_state_reg == US_IDLE && us_in_valid && us_in_sop && us_adv &&
    us_in_is_req |=> us_out_prio && usid_reg == $past(
    cfg_us_req_sid[us_in_chan]))
    else $error("request not steered to request session");

  cov_ts_gap: cover property (ds_seq_gap);
  cov_unknown: cover property (ds_unknown_sess);
  cov_psp_frame: cover property (ds_out_valid && ds_out_psp && ds_out_last);
  cov_us_req: cover property (us_out_valid && us_out_sop && us_out_prio);
endmodule

//--- verif/core_model.sv
`timescale 1ns/10ps
// ==========================================================
// Network side of the central MAC core, upstream receive
module core_model (
  // Clock
  input wire logic clk,
  // Upstream tunnel stream from the unit
  input wire logic [7:0] us_out_data,
  input wire logic us_out_valid,
  input wire logic us_out_sop,
  input wire logic us_out_eop,
  input wire logic us_out_prio,
  input wire logic [pw_pkg::DSCP_W-1:0] us_out_dscp,
  output logic us_out_ready,
  // Stall control
  input wire logic slow
);
  import pw_pkg::*;
  logic [16:0] got[$];
  logic tog = 1'b0;
  // Slow mode accepts every other cycle so the unit must hold its bytes
  always @(negedge clk) begin
    tog <= ~tog;
    us_out_ready <= ~slow | tog;
  end
  // Each packet opens with its session id, MSB first
  always @(posedge clk) begin
    if (us_out_valid && us_out_ready)
      got.push_back({us_out_prio, us_out_sop, us_out_eop, us_out_dscp,
                     us_out_data});
  end
endmodule

//--- verif/cable_phy_pseudowire_framer_bench.sv
`timescale 1ns/10ps
module cable_phy_pseudowire_framer_bench;
  import pw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_DS-1:0] cfg_ds_en;
  logic [NUM_DS-1:0][SID_W-1:0] cfg_ds_sid;
  logic [NUM_DS-1:0] cfg_ds_ofdm;
  logic [NUM_US-1:0][SID_W-1:0] cfg_us_sid;
  logic [NUM_US-1:0][SID_W-1:0] cfg_us_req_sid;
  logic [NUM_US-1:0][DSCP_W-1:0] cfg_us_dscp;
  logic [NUM_US-1:0][DSCP_W-1:0] cfg_us_req_dscp;
  logic [7:0] ds_in_data, ds_out_data, us_in_data, us_out_data;
  logic ds_in_valid, ds_in_sop, ds_in_eop, ds_in_ready;
  logic ds_out_valid, ds_out_last, ds_out_tsp_start, ds_out_psp;
  logic [DS_IDX_W-1:0] ds_out_chan;
  logic ds_out_ready = 1'b1;
  logic ds_seq_gap, ds_unknown_sess, ds_ts_short;
  logic us_in_valid, us_in_sop, us_in_eop, us_in_is_req, us_in_ready;
  logic [US_IDX_W-1:0] us_in_chan;
  logic us_out_valid, us_out_sop, us_out_eop, us_out_prio, us_out_ready;
  logic [DSCP_W-1:0] us_out_dscp;
  logic ds_stall = 1'b0;
  logic slow = 1'b0;
  logic [12:0] dsq[$];
  int gaps, unk, shorts, err_total, total_checks, cyc;
  // Header length in words; varied so the parser must honour it
  int ihl = 5;

  cable_phy_pseudowire_framer i_cable_phy_pseudowire_framer (.clk, .rst,
    .cfg_ds_en, .cfg_ds_sid, .cfg_ds_ofdm, .cfg_us_sid, .cfg_us_req_sid,
    .cfg_us_dscp, .cfg_us_req_dscp, .ds_in_data, .ds_in_valid, .ds_in_sop,
    .ds_in_eop, .ds_in_ready, .ds_out_data, .ds_out_valid, .ds_out_last,
    .ds_out_tsp_start, .ds_out_psp, .ds_out_chan, .ds_out_ready,
    .ds_seq_gap, .ds_unknown_sess, .ds_ts_short, .us_in_data,
    .us_in_valid, .us_in_sop, .us_in_eop, .us_in_is_req, .us_in_chan,
    .us_in_ready, .us_out_data, .us_out_valid, .us_out_sop, .us_out_eop,
    .us_out_prio, .us_out_dscp, .us_out_ready);

  core_model i_core_model (.clk, .us_out_data, .us_out_valid, .us_out_sop,
    .us_out_eop, .us_out_prio, .us_out_dscp, .us_out_ready, .slow);

  // ==========================================================
  // Clock, modulator sink and event counters
  always #25 clk = ~clk;
  always @(negedge clk) ds_out_ready <= ~ds_stall | ~ds_out_ready;
  always @(posedge clk) begin
    if (ds_out_valid && ds_out_ready)
      dsq.push_back({ds_out_chan, ds_out_psp, ds_out_tsp_start,
                     ds_out_last, ds_out_data});
    if (ds_seq_gap === 1'b1) gaps++;
    if (ds_unknown_sess === 1'b1) unk++;
    if (ds_ts_short === 1'b1) shorts++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared helpers
  function automatic logic [7:0] pay(input int i);
    return i[7:0] ^ 8'h5A;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Hold the request until ready is high at a rising edge
  task automatic hs(input bit up);
    #1;
    while ((up ? us_in_ready : ds_in_ready) !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
  endtask

  task automatic ds_byte(input logic [7:0] d, input logic s, input logic e);
    @(negedge clk);
    ds_in_data = d;
    ds_in_sop = s;
    ds_in_eop = e;
    ds_in_valid = 1'b1;
    hs(1'b0);
  endtask

  task automatic ds_pkt(input logic [31:0] sid, input logic ts,
                        input logic [15:0] seq, input int n);
    for (int i = 0; i < ihl * 4; i++)
      ds_byte(i == 0 ? {4'h4, ihl[3:0]} : 8'h00, i == 0, 1'b0);
    for (int i = 3; i >= 0; i--) ds_byte(sid[i*8 +: 8], 1'b0, 1'b0);
    if (ts) begin
      for (int i = 0; i < 4; i++)
        ds_byte(i == 2 ? seq[15:8] : i == 3 ? seq[7:0] : 8'h00, 1'b0, 1'b0);
    end
    for (int i = 0; i < n; i++) ds_byte(pay(i), 1'b0, i == n - 1);
    @(negedge clk);
    ds_in_valid = 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic ds_expect(input logic [1:0] ch, input logic packet_streaming_mode,
                           input int n);
    logic [12:0] w;
    check("ds_count", dsq.size(), n);
    for (int i = 0; i < n && dsq.size() > 0; i++) begin
      w = dsq.pop_front();
      check("ds_byte", w, {ch, packet_streaming_mode, ~packet_streaming_mode && (i % 188 == 0), i == n - 1,
                           pay(i)});
    end
    dsq.delete();
  endtask

  task automatic us_frame(input logic rq, input logic ch, input int n);
    logic [31:0] sid;
    logic [DSCP_W-1:0] dscp;
    logic [16:0] w;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      us_in_data = pay(i);
      us_in_sop = i == 0;
      us_in_eop = i == n - 1;
      us_in_is_req = rq;
      us_in_chan = ch;
      us_in_valid = 1'b1;
      hs(1'b1);
    end
    @(negedge clk);
    us_in_valid = 1'b0;
    repeat (20) @(posedge clk);
    sid = rq ? cfg_us_req_sid[ch] : cfg_us_sid[ch];
    dscp = rq ? cfg_us_req_dscp[ch] : cfg_us_dscp[ch];
    check("us_count", i_core_model.got.size(), n + 4);
    for (int i = 0; i < n + 4 && i_core_model.got.size() > 0; i++) begin
      w = i_core_model.got.pop_front();
      check("us_byte", w, {rq, i == 0, i == n + 3, dscp,
        i < 4 ? sid[(3 - i) * 8 +: 8] : pay(i - 4)});
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_ts_seq();
    ds_stall = 1'b1;
    ds_pkt(cfg_ds_sid[1], 1'b1, 16'hFFFF, 376);
    ds_expect(2'h1, 1'b0, 376);
    ds_pkt(cfg_ds_sid[1], 1'b1, 16'h0000, 188);
    ds_expect(2'h1, 1'b0, 188);
    check("gap_wrap", gaps, 0);
    ds_pkt(cfg_ds_sid[1], 1'b1, 16'h0002, 188);
    ds_expect(2'h1, 1'b0, 188);
    check("gap_lost", gaps, 1);
    check("ts_exact", shorts, 0);
    ds_stall = 1'b0;
  endtask

  task automatic t_unknown();
    @(negedge clk);
    cfg_ds_en[3] = 1'b0;
    ds_pkt(cfg_ds_sid[3], 1'b0, 16'h0000, 9);
    ds_pkt(32'hDEAD0000, 1'b1, 16'h0000, 9);
    check("unk_out", dsq.size(), 0);
    check("unk_evt", unk, 2);
  endtask

  task automatic t_psp();
    ihl = 6;
    ds_pkt(cfg_ds_sid[2], 1'b0, 16'h0000, 10);
    ihl = 5;
    ds_expect(2'h2, 1'b1, 10);
    ds_pkt(cfg_ds_sid[0], 1'b1, 16'h0007, 188);
    ds_expect(2'h0, 1'b0, 188);
    ds_pkt(cfg_ds_sid[0], 1'b1, 16'h0008, 100);
    ds_expect(2'h0, 1'b0, 100);
    check("ts_short", shorts, 1);
    check("gap_kept", gaps, 1);
  endtask

  task automatic t_upstream();
    slow = 1'b1;
    us_frame(1'b0, 1'b0, 6);
    us_frame(1'b1, 1'b1, 3);
    slow = 1'b0;
    us_frame(1'b1, 1'b0, 2);
    us_frame(1'b0, 1'b1, 5);
  endtask

  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    cfg_ds_en = 4'hF;
    cfg_ds_ofdm = 4'h4;
    // Each channel gets its own session; requests ride a separate one
    for (int i = 0; i < NUM_DS; i++) cfg_ds_sid[i] = 32'hA5000010 + i;
    for (int i = 0; i < NUM_US; i++) begin
      cfg_us_sid[i] = 32'h3C000020 + i;
      cfg_us_req_sid[i] = 32'h3C000040 + i;
      cfg_us_dscp[i] = 6'(6'h0A + i);
      cfg_us_req_dscp[i] = 6'(6'h2E - i);
    end
    {ds_in_data, ds_in_valid, ds_in_sop, ds_in_eop} = 11'h000;
    {us_in_data, us_in_valid, us_in_sop, us_in_eop} = 11'h000;
    {us_in_is_req, us_in_chan} = 2'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_ts_seq();
    t_unknown();
    t_psp();
    t_upstream();
    wrap_up();
  end
endmodule
